// ---- bench/aofc_frame_ctl_properties.sv ----
// Checker: register bus and range output properties of the frame control block
`timescale 1ns/1ps
module aofc_frame_ctl_properties (
  // System and bus
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Range outputs
  input wire logic        onchip_ref_off,
  input wire logic [3:0]  span_select,
  input wire logic        span_bipolar,
  input wire logic        span_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic acc    = psel && penable;
  wire logic rd     = acc && !pwrite;
  wire logic wr_rng = acc && pwrite && paddr == 8'h14 && pstrb[0];
  ready_high_a:
    assert property (pready) else $error("pready low");
  err_decode_a:
    assert property (acc && paddr[1:0] == 2'h0 |->
      pslverr == !(paddr inside {8'h10, 8'h14, 8'h20, 8'h24})) else $error("pslverr decode");
  err_idle_a:
    assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  ctl_rsvd_a:
    assert property (rd && paddr == 8'h10 |-> (prdata & ~aofc_pkg::MASK_FRAME_CTL) == 32'h0)
      else $error("control reserved bits set");
  rng_rsvd_a:
    assert property (rd && paddr == 8'h14 |-> (prdata & ~aofc_pkg::MASK_RANGE_CFG) == 32'h0)
      else $error("range reserved bits set");
  ref_off_a:
    assert property (wr_rng |=> onchip_ref_off == $past(pwdata[6])) else $error("ref off");
  ref_hold_a:
    assert property (!wr_rng |=> $stable(onchip_ref_off)) else $error("ref off moved");
  span_sel_a:
    assert property (wr_rng |=> span_select == $past(pwdata[3:0])) else $error("span code");
  span_kind_a:
    assert property (span_bipolar == !span_select[3] && span_valid ==
      (span_select < 4'h5 || span_select inside {[4'h8:4'hB]})) else $error("span kind");
endmodule : aofc_frame_ctl_properties

bind aofc_frame_ctl aofc_frame_ctl_properties u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .onchip_ref_off(onchip_ref_off), .span_select(span_select),
  .span_bipolar(span_bipolar), .span_valid(span_valid));

// ---- bench/aofc_host_model.sv ----
// Host model: clocks serial output frames in over the link
`timescale 1ns/1ps
module aofc_host_model (
  // Link
  output logic      link_clk,
  output logic      frame_start,
  input  wire logic serial_out_lines
);
  initial begin
    link_clk = 1'b0;
    frame_start = 1'b0;
  end
  // Clock stands still between frames; lead-in edges let settings cross
  task automatic read_frame(input int len, output logic [31:0] got);
    got = 32'h0;
    #7;
    repeat (8) begin
      #32 link_clk = 1'b1;
      #32 link_clk = 1'b0;
    end
    frame_start = 1'b1;
    #32 link_clk = 1'b1;
    #1 frame_start = 1'b0;
    for (int i = 0; i < len; i++) begin
      #31 link_clk = 1'b0;
      #16 got = {got[30:0], serial_out_lines};
      #16 link_clk = 1'b1;
    end
    #32 link_clk = 1'b0;
  endtask : read_frame
endmodule : aofc_host_model

// ---- bench/tb_adc_output_frame_config.sv ----
// Testbench: registers, range outputs and serial frame content
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_adc_output_frame_config;
  logic                  ref_clk = 1'b0;
  logic                  rst_n, psel, penable, pwrite, conv_valid, pready, pslverr, e;
  logic                  ref_off, bip, sv, link_clk, frame_start, sdo;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, ctl, got, q;
  logic [3:0]            pstrb, span, rng, id;
  logic [17:0]           res;
  logic [5:0]            flen;
  aofc_pkg::aofc_alarm_t alm;
  aofc_pkg::aofc_frame_t ef;
  int                    failures, n_checks, cyc;

  aofc_frame_ctl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .conv_result(res), .conv_valid(conv_valid),
    .alarm_supply_hi(alm.supply_hi), .alarm_supply_lo(alm.supply_lo),
    .alarm_input_hi(alm.input_hi), .alarm_input_lo(alm.input_lo), .onchip_ref_off(ref_off),
    .span_select(span), .span_bipolar(bip), .span_valid(sv), .link_clk(link_clk),
    .frame_start(frame_start), .serial_out_lines(sdo), .frame_length(flen));
  aofc_host_model u_host (.link_clk(link_clk), .frame_start(frame_start),
    .serial_out_lines(sdo));

  always #5 ref_clk = ~ref_clk;
  // Run is about 9400 cycles; ceiling leaves ample margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHK(nm, x, q)
    `CHK("pslverr", xe, e)
  endtask : rd_chk

  function automatic aofc_pkg::aofc_frame_t add(aofc_pkg::aofc_frame_t f, logic [3:0] v,
                                                 int n);
    f.bits = (f.bits << n) | 32'(v);
    f.len = f.len + 6'(n);
    return f;
  endfunction : add

  function automatic aofc_pkg::aofc_frame_t exp_frame(logic [31:0] c, logic [3:0] r,
    logic [3:0] u, logic [17:0] d, aofc_pkg::aofc_alarm_t al);
    aofc_pkg::aofc_frame_t f;
    logic [17:0]           v;
    case (c[2:0])
      3'h4: v = 18'h00000;
      3'h5: v = 18'h3FFFF;
      3'h6: v = 18'h2AAAA;
      3'h7: v = 18'h0CCCC;
      default: v = d;
    endcase
    f.bits = {14'h0, v};
    f.len = 6'h12;
    if (c[14]) f = add(f, u, 4);
    if (c[12]) f = add(f, {3'h0, al.supply_hi}, 1);
    if (c[13]) f = add(f, {3'h0, al.supply_lo}, 1);
    if (c[10]) f = add(f, {3'h0, al.input_hi}, 1);
    if (c[11]) f = add(f, {3'h0, al.input_lo}, 1);
    if (c[8]) f = add(f, r, 4);
    if (c[3]) f = add(f, {2'h0, ^v, ^f.bits}, 2);
    return f;
  endfunction : exp_frame

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, res, conv_valid, alm} = '0;
    void'($urandom(44));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk("ctl reset", 8'h10, aofc_pkg::RST_FRAME_CTL, 1'b0);
    rd_chk("rng reset", 8'h14, aofc_pkg::RST_RANGE_CFG, 1'b0);
    rd_chk("unmapped", 8'h30, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, 4'hF);
    rd_chk("ctl mask", 8'h10, aofc_pkg::MASK_FRAME_CTL, 1'b0);
    apb(1'b1, 8'h10, 32'h0, 4'h2);
    rd_chk("ctl byte", 8'h10, 32'h0000000F, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'h14, 32'hFFFFFFF0 | i, 4'hF);
      @(posedge ref_clk);
      `CHK("span valid", i < 5 || (i > 7 && i < 12), sv)
      `CHK("span code", i[3:0], span)
      `CHK("ref off", 1'b1, ref_off)
    end
    rd_chk("rng mask", 8'h14, aofc_pkg::MASK_RANGE_CFG, 1'b0);
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      ctl = (i == 1) ? 32'h7D08 : ($urandom & aofc_pkg::MASK_FRAME_CTL);
      ctl[2:0] = i[2:0];
      rng = 4'($urandom);
      id = 4'($urandom);
      res <= 18'($urandom);
      alm <= 4'($urandom);
      conv_valid <= 1'b1;
      @(posedge ref_clk);
      conv_valid <= 1'b0;
      apb(1'b1, 8'h24, {28'h0, id}, 4'hF);
      apb(1'b1, 8'h10, ctl, 4'hF);
      apb(1'b1, 8'h14, {28'h0, rng}, 4'hF);
      @(posedge ref_clk);
      `CHK("ref on", 1'b0, ref_off)
      rd_chk("alarms", 8'h20, {16'h0, alm.supply_lo, alm.supply_hi, 2'h0, alm.input_lo,
        alm.input_hi, 10'h0}, 1'b0);
      ef = exp_frame(ctl, rng, id, res, alm);
      `CHK("frame length", ef.len, flen)
      u_host.read_frame(int'(ef.len), got);
      `CHK("frame bits", ef.bits, got)
      `CHK("data word", ef.bits >> (ef.len - 18), got >> (ef.len - 18))
      if (ctl[3]) `CHK("parity bits", ef.bits[1:0], got[1:0])
    end
    wrap_up();
  end
endmodule : tb_adc_output_frame_config

// ---- design/aofc_frame_ctl.sv ----
// Output frame builder with APB register slave and link-side shifter
`timescale 1ns/1ps
// Contract
// - Address-include bit 14 inserts 4-bit ID
// - Bits 13-12 select supply alarm flags
// - Bits 11-10 select input alarm flags
// - Bit 8 inserts 4-bit range code
// - Bit 3 appends two parity bits last
// - Result parity: even over data only
// - Parity lengthens frame by two bits
// - Pattern 0xx sends conversion result
// - Patterns 1xx send fixed test data
// - Reserved control bits read zero
// - Control register at byte 10h-13h
// - Range register: bit 6, bits 3-0
// - Range code selects input span
// - Reference-off bit disables onchip reference
// - Alarm flags follow live condition
module aofc_frame_ctl (
  // System
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Converter side
  input  wire logic [17:0] conv_result,
  input  wire logic        conv_valid,
  input  wire logic        alarm_supply_hi,
  input  wire logic        alarm_supply_lo,
  input  wire logic        alarm_input_hi,
  input  wire logic        alarm_input_lo,
  output logic             onchip_ref_off,
  output logic [3:0]       span_select,
  output logic             span_bipolar,
  output logic             span_valid,
  // Link
  input  wire logic        link_clk,
  input  wire logic        frame_start,
  output logic             serial_out_lines,
  output logic [5:0]       frame_length
);
  localparam int RW = aofc_pkg::RES_W;
  localparam int FW = aofc_pkg::FRAME_W;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Longest frame is the data word plus fourteen appended bits
  if (RW + 14 > FW) begin : g_bad_fw
    $error("frame width too small for the longest frame");
  end
  if (RW != 18) begin : g_bad_rw
    $error("result width must match the converter port");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [31:0] ctl_ff;
  logic [31:0] rng_ff;
  logic [3:0]  uid_ff;
  logic [RW-1:0] res_ff;
  aofc_pkg::aofc_alarm_t alm_s1_ff;
  aofc_pkg::aofc_alarm_t alm_s2_ff;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Unaligned addresses miss every register
  wire acc      = psel & penable;
  wire wr_acc   = acc & pwrite;
  wire hit_ctl  = (paddr == aofc_pkg::OFS_FRAME_CTL);
  wire hit_rng  = (paddr == aofc_pkg::OFS_RANGE_CFG);
  wire hit_alm  = (paddr == aofc_pkg::OFS_ALARM_STAT);
  wire hit_uid  = (paddr == aofc_pkg::OFS_UNIT_ID);
  wire hit_any  = hit_ctl | hit_rng | hit_alm | hit_uid;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb,
                                             input logic [31:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r & mask;
  endfunction : byte_merge

  // Byte-wise writes; reserved bits masked off
  wire [31:0] nxt_ctl = byte_merge(ctl_ff, pwdata, pstrb,
                                   aofc_pkg::MASK_FRAME_CTL);
  wire [31:0] nxt_rng = byte_merge(rng_ff, pwdata, pstrb,
                                   aofc_pkg::MASK_RANGE_CFG);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_ff <= aofc_pkg::RST_FRAME_CTL;
      rng_ff <= aofc_pkg::RST_RANGE_CFG;
      uid_ff <= aofc_pkg::RST_UNIT_ID;
    end else if (wr_acc) begin
      if (hit_ctl) ctl_ff <= nxt_ctl;
      if (hit_rng) rng_ff <= nxt_rng;
      if (hit_uid && pstrb[0]) uid_ff <= pwdata[3:0];
    end
  end

  // Alarm pins are asynchronous: two-stage sync
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alm_s1_ff <= '0;
      alm_s2_ff <= '0;
    end else begin
      alm_s1_ff <= '{alarm_supply_hi, alarm_supply_lo, alarm_input_hi, alarm_input_lo};
      alm_s2_ff <= alm_s1_ff;
    end
  end

  // Conversion result captured on its valid strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_ff <= '0;
    end else if (conv_valid) begin
      res_ff <= conv_result;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  // Unit ID and alarm status are extra views for the host
  wire [31:0] alm_word = {16'h0000, alm_s2_ff.supply_lo, alm_s2_ff.supply_hi, 2'h0,
                          alm_s2_ff.input_lo, alm_s2_ff.input_hi, 10'h000};
  wire [31:0] rd_mux = hit_ctl ? ctl_ff :
                       hit_rng ? rng_ff :
                       hit_alm ? alm_word :
                       hit_uid ? {28'h0000000, uid_ff} : 32'h0000_0000;

  // Zero wait states; unmapped answers with error
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Range and reference outputs
  // ------------------------------------------------------------
  assign onchip_ref_off = rng_ff[aofc_pkg::POS_REF_OFF];
  assign span_select    = rng_ff[3:0];
  assign span_bipolar   = ~rng_ff[3];
  // Codes 0101b-0111b and 11xxb select no span
  assign span_valid     = rng_ff[3] ? ~rng_ff[2] : (rng_ff[2:0] <= 3'h4);

  // ------------------------------------------------------------
  // Frame assembly
  // ------------------------------------------------------------
  aofc_pkg::aofc_ctl_t ctl;
  assign ctl = '{unit_id_on: ctl_ff[aofc_pkg::POS_UNIT_ID],
                 supply_sel: ctl_ff[aofc_pkg::POS_SUPPLY_LO +: 2],
                 input_sel:  ctl_ff[aofc_pkg::POS_INPUT_LO +: 2],
                 span_on:    ctl_ff[aofc_pkg::POS_SPAN],
                 parity_on:  ctl_ff[aofc_pkg::POS_PARITY],
                 pattern:    ctl_ff[2:0]};

  // Test patterns, MSB first
  // Single-bit pattern starts with a one at the MSB
  logic [RW-1:0] alt1;
  logic [RW-1:0] alt2;
  genvar g;
  generate
    for (g = 0; g < RW; g++) begin : g_pat
      assign alt1[g] = 1'(g % 2);
      assign alt2[g] = 1'((g / 2) % 2);
    end
  endgenerate

  wire [RW-1:0] data_word =
    ~ctl.pattern[2]                      ? res_ff :
    (ctl.pattern == aofc_pkg::PAT_ZEROS) ? {RW{1'b0}} :
    (ctl.pattern == aofc_pkg::PAT_ONES)  ? {RW{1'b1}} :
    (ctl.pattern == aofc_pkg::PAT_ALT1)  ? alt1 : alt2;

  // Fields and their widths, in frame order
  wire [3:0] uid_f = uid_ff;
  wire [1:0] sup_f = {alm_s2_ff.supply_hi, alm_s2_ff.supply_lo};
  wire [1:0] inp_f = {alm_s2_ff.input_hi, alm_s2_ff.input_lo};
  wire [3:0] spn_f = rng_ff[3:0];

  // Single selection sends one bit; both send high then low
  function automatic logic [1:0] sel_bits(input logic [1:0] sel, input logic [1:0] f);
    return (sel == 2'h3) ? f : {1'b0, (sel[0] & f[1]) | (sel[1] & f[0])};
  endfunction : sel_bits

  function automatic logic [1:0] sel_len(input logic [1:0] sel);
    return (sel == 2'h3) ? 2'h2 : ((sel == 2'h0) ? 2'h0 : 2'h1);
  endfunction : sel_len

  logic [FW-1:0] body;
  logic [5:0]    blen;
  logic [1:0]    sb;
  logic [1:0]    ib;
  logic [1:0]    sl;
  logic [1:0]    il;
  logic          p_res;
  logic          p_frm;

  // Build left-aligned frame by appending each enabled field
  always_comb begin
    body  = '0;
    blen  = 6'(RW);
    sb    = sel_bits(ctl.supply_sel, sup_f);
    ib    = sel_bits(ctl.input_sel, inp_f);
    sl    = sel_len(ctl.supply_sel);
    il    = sel_len(ctl.input_sel);
    body[FW-1 -: RW] = data_word;
    if (ctl.unit_id_on) begin
      body[FW-1-blen -: 4] = uid_f;
      blen = blen + 6'h04;
    end
    if (sl != 2'h0) begin
      if (sl == 2'h2) body[FW-1-blen -: 2] = sb;
      else            body[FW-1-blen]      = sb[0];
      blen = blen + {4'h0, sl};
    end
    if (il != 2'h0) begin
      if (il == 2'h2) body[FW-1-blen -: 2] = ib;
      else            body[FW-1-blen]      = ib[0];
      blen = blen + {4'h0, il};
    end
    if (ctl.span_on) begin
      body[FW-1-blen -: 4] = spn_f;
      blen = blen + 6'h04;
    end
    // Padding zeros leave the frame parity unchanged
    p_res = ^data_word;
    p_frm = ^body;
    if (ctl.parity_on) begin
      body[FW-1-blen]      = p_res;
      body[FW-2-blen]      = p_frm;
      blen = blen + 6'h02;
    end
  end

  // Registered frame; crosses to the link side by handshake only
  aofc_pkg::aofc_frame_t frame_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) frame_ff <= '0;
    else        frame_ff <= '{bits: body, len: blen};
  end

  assign frame_length = frame_ff.len;

  // ------------------------------------------------------------
  // Crossing, system side
  // ------------------------------------------------------------
  // Toggle handshake: a new offer waits until the last one was taken,
  // so the held word never moves while the link side samples it
  logic                  req_ff;
  logic                  ack_s1_ff;
  logic                  ack_s2_ff;
  logic                  req_s1_ff;
  logic                  req_s2_ff;
  logic                  ack_ff;
  aofc_pkg::aofc_frame_t hold_ff;
  aofc_pkg::aofc_frame_t lnk_frame_ff;

  wire offer_free = (req_ff == ack_s2_ff);
  wire offer_new  = offer_free & (frame_ff != hold_ff);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ff  <= 1'b0;
      hold_ff <= '0;
    end else if (offer_new) begin
      req_ff  <= ~req_ff;
      hold_ff <= frame_ff;
    end
  end

  // ------------------------------------------------------------
  // Crossing, link side
  // ------------------------------------------------------------
  // Link clock stands still between frames: the host must give
  // six edges after its last setting change before a start
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_s1_ff    <= 1'b0;
      req_s2_ff    <= 1'b0;
      ack_ff       <= 1'b0;
      lnk_frame_ff <= '0;
    end else begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      if (req_s2_ff != ack_ff) begin
        ack_ff       <= req_s2_ff;
        lnk_frame_ff <= hold_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // Link side
  // ------------------------------------------------------------
  // Done flag unused: the host counts the bits itself
  aofc_shifter #(
    .W (FW)
  ) u_shift (
    .link_clk         (link_clk),
    .frame_start      (frame_start),
    .frame_bits       (lnk_frame_ff.bits),
    .frame_len        (lnk_frame_ff.len),
    .serial_out_lines (serial_out_lines),
    .frame_done       ()
  );
endmodule : aofc_frame_ctl

// ---- design/aofc_shifter.sv ----
// Link-side shifter: loads a frame and drives it MSB first on the serial clock
`timescale 1ns/1ps
module aofc_shifter #(
  parameter int W = 32
) (
  // Link clock and frame strobe
  input  wire logic         link_clk,
  input  wire logic         frame_start,
  // Frame content, stable while frames run
  input  wire logic [W-1:0] frame_bits,
  input  wire logic [5:0]   frame_len,
  // Serial output
  output logic              serial_out_lines,
  output logic              frame_done
);
  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  logic [W-1:0] shift_ff;
  logic [5:0]   left_ff;

  // Length counter is six bits wide
  if (W < 2 || W > 63) begin : g_bad_w
    $error("shifter width out of range");
  end

  // No reset here: the link clock may be stopped during reset
  always_ff @(posedge link_clk) begin
    if (frame_start) begin
      shift_ff <= frame_bits;
      left_ff  <= frame_len;
    end else if (left_ff != 6'h00) begin
      shift_ff <= {shift_ff[W-2:0], 1'b0};
      left_ff  <= left_ff - 6'h01;
    end
  end

  assign serial_out_lines = shift_ff[W-1];
  assign frame_done       = (left_ff == 6'h00);
endmodule : aofc_shifter

// ---- pkg/aofc_pkg.sv ----
// Package: register map, field layout and frame types for the output frame builder
package aofc_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_FRAME_CTL  = 8'h10;
  localparam logic [7:0] OFS_RANGE_CFG  = 8'h14;
  localparam logic [7:0] OFS_ALARM_STAT = 8'h20;
  localparam logic [7:0] OFS_UNIT_ID    = 8'h24;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int POS_UNIT_ID   = 14;
  localparam int POS_SUPPLY_LO = 12;
  localparam int POS_INPUT_LO  = 10;
  localparam int POS_SPAN      = 8;
  localparam int POS_PARITY    = 3;
  localparam int POS_REF_OFF   = 6;
  // Writable bit masks; all else reads zero
  localparam logic [31:0] MASK_FRAME_CTL = 32'h0000_7D0F;
  localparam logic [31:0] MASK_RANGE_CFG = 32'h0000_004F;
  localparam logic [31:0] RST_FRAME_CTL  = 32'h0000_0000;
  localparam logic [31:0] RST_RANGE_CFG  = 32'h0000_0000;
  localparam logic [3:0]  RST_UNIT_ID    = 4'h0;
  // ------------------------------------------------------------
  // Data patterns
  // ------------------------------------------------------------
  localparam logic [2:0] PAT_ZEROS = 3'h4;
  localparam logic [2:0] PAT_ONES  = 3'h5;
  localparam logic [2:0] PAT_ALT1  = 3'h6;
  localparam logic [2:0] PAT_ALT2  = 3'h7;
  // Widths
  localparam int RES_W   = 18;
  localparam int FRAME_W = 32;

  typedef struct packed {
    logic       unit_id_on;
    logic [1:0] supply_sel;
    logic [1:0] input_sel;
    logic       span_on;
    logic       parity_on;
    logic [2:0] pattern;
  } aofc_ctl_t;

  typedef struct packed {
    logic supply_hi;
    logic supply_lo;
    logic input_hi;
    logic input_lo;
  } aofc_alarm_t;

  typedef struct packed {
    logic [FRAME_W-1:0] bits;
    logic [5:0]         len;
  } aofc_frame_t;
endpackage : aofc_pkg
